// File: design/rsm_pkg.sv
// Package for the reading store and monitor block: sizes, codes and timing counts.
// Assumes a 200 MHz system clock and a single synchronous clock domain.
package rsm_pkg;
  localparam int unsigned MEM_DEPTH       = 50000;
  localparam int unsigned PTR_W           = 16;
  localparam int unsigned CH_W            = 8;
  localparam int unsigned NUM_CH          = 16;
  localparam int unsigned VAL_W           = 24;
  localparam int unsigned TS_W            = 32;
  localparam int unsigned ALM_W           = 2;
  localparam int unsigned ENTRY_W         = VAL_W + TS_W + CH_W + ALM_W;
  localparam int unsigned HIST_DEPTH      = 100;
  localparam int unsigned HIST_W          = 7;
  localparam int unsigned CNT_W           = 16;
  localparam int unsigned SUM_W           = 40;
  localparam int unsigned FIFO_DEPTH      = 32;
  localparam logic [ALM_W-1:0] ALM_NONE   = 2'h0;
  localparam logic [ALM_W-1:0] ALM_LO     = 2'h1;
  localparam logic [ALM_W-1:0] ALM_HI     = 2'h2;
  localparam logic [1:0] KIND_MUX         = 2'h0;
  localparam logic [1:0] KIND_DIG         = 2'h1;
  localparam logic [1:0] KIND_TOT         = 2'h2;
  localparam logic [1:0] KIND_OTHER       = 2'h3;
  localparam int unsigned CLK_MHZ         = 200;
  localparam int unsigned SETTLE_MS       = 2000;
  localparam longint unsigned SETTLE_CYC  = longint'(SETTLE_MS) * 1000 * CLK_MHZ;
  typedef enum logic [1:0] {
    RSM_IDLE_TYPE   = 2'b00,
    RSM_SETTLE_TYPE = 2'b01,
    RSM_RUN_TYPE    = 2'b11
  } rsm_mon_type;
endpackage

// File: design/rsm_fifo_if.sv
// Interface carrying readings between the store and its output buffer.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface rsm_fifo_if #(parameter int unsigned W = 8);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// File: design/rsm_fifo.sv
// Output buffer FIFO with valid and ready on both sides.
// Assumes one clock and an asynchronous active low reset.
`timescale 1ns/1ps
module rsm_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 32,
  parameter int unsigned AW    = 5
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  rsm_fifo_if.fifo  f
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          push;
  logic          pop;

  assign f.in_ready  = (count != (AW+1)'(DEPTH));
  assign f.out_valid = (count != '0);
  assign f.out_data  = mem[rd_ptr];
  assign push        = f.in_valid && f.in_ready;
  assign pop         = f.out_valid && f.out_ready;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= f.in_data;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  fifo_bound_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    count <= (AW+1)'(DEPTH)) else $error("FIFO count past depth.");
endmodule // rsm_fifo

// File: design/rsm_store.sv
// Reading store, per-channel statistics and monitor arbitration.
// Assumes the scan engine and host drive one-cycle requests synchronous to clk_i.
`timescale 1ns/1ps
module rsm_store
  import rsm_pkg::*;
#(
  parameter longint unsigned SETTLE_CYCLES = SETTLE_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  // Scan engine side.
  input  wire logic                 scan_start_i,
  input  wire logic                 scan_active_i,
  input  wire logic                 sweep_end_i,
  input  wire logic                 alarm_scan_mode_i,
  input  wire logic                 rd_valid_i,
  input  wire logic                 rd_direct_i,
  input  wire logic [CH_W-1:0]      rd_ch_i,
  input  wire logic [VAL_W-1:0]     rd_val_i,
  input  wire logic [TS_W-1:0]      rd_ts_i,
  input  wire logic                 meas_ready_i,
  output logic                      sweep_req_o,
  output logic                      mon_meas_o,
  output logic [CH_W-1:0]           mon_meas_ch_o,
  // Channel configuration.
  input  wire logic [NUM_CH-1:0]    in_scan_list_i,
  input  wire logic [2*NUM_CH-1:0]  ch_kind_i,
  input  wire logic                 meter_present_i,
  input  wire logic                 meter_enable_i,
  input  wire logic [VAL_W-1:0]     scale_m_i,
  input  wire logic [VAL_W-1:0]     scale_b_i,
  input  wire logic [VAL_W-1:0]     lim_lo_i,
  input  wire logic [VAL_W-1:0]     lim_hi_i,
  // External instrument lines.
  input  wire logic                 ext_closed_i,
  output logic                      ch_closed_o,
  input  wire logic                 ch_advance_i,
  output logic                      ch_advance_o,
  // Host requests.
  input  wire logic                 fetch_i,
  input  wire logic [PTR_W-1:0]     fetch_idx_i,
  input  wire logic                 remove_i,
  input  wire logic [PTR_W-1:0]     remove_n_i,
  input  wire logic                 stat_req_i,
  input  wire logic                 stat_clr_i,
  input  wire logic [CH_W-1:0]      stat_ch_i,
  input  wire logic [HIST_W-1:0]    hist_idx_i,
  output logic [VAL_W-1:0]          stat_min_o,
  output logic [TS_W-1:0]           stat_min_t_o,
  output logic [VAL_W-1:0]          stat_max_o,
  output logic [TS_W-1:0]           stat_max_t_o,
  output logic [VAL_W-1:0]          stat_avg_o,
  output logic [CNT_W-1:0]          stat_cnt_o,
  output logic [VAL_W-1:0]          stat_ptp_o,
  output logic [VAL_W-1:0]          stat_last_o,
  output logic [VAL_W-1:0]          hist_val_o,
  output logic                      stat_valid_o,
  output logic [PTR_W:0]            points_o,
  output logic                      mem_overflow_o,
  output logic                      out_valid_o,
  input  wire logic                 out_ready_i,
  output logic [ENTRY_W-1:0]        out_data_o,
  // Monitor control.
  input  wire logic                 mon_on_i,
  input  wire logic                 mon_local_i,
  input  wire logic [CH_W-1:0]      mon_ch_i,
  output logic                      mon_refused_o,
  output logic [VAL_W-1:0]          mon_data_o,
  output logic                      alarm_push_o,
  output logic [ENTRY_W-1:0]        alarm_data_o,
  output logic                      totalizer_reset_o
);
  // ==========================================================================
  // Helpers
  function automatic logic [ALM_W-1:0] alm_code(input logic [VAL_W-1:0] v);
    if (v < lim_lo_i) begin
      return ALM_LO;
    end else if (v > lim_hi_i) begin
      return ALM_HI;
    end
    return ALM_NONE;
  endfunction

  function automatic logic [PTR_W-1:0] wrap(input logic [PTR_W:0] p);
    return (p >= (PTR_W+1)'(MEM_DEPTH)) ? PTR_W'(p - (PTR_W+1)'(MEM_DEPTH)) : PTR_W'(p);
  endfunction

  // ==========================================================================
  // Reading memory
  logic [ENTRY_W-1:0] mem [MEM_DEPTH];
  logic [PTR_W-1:0]   head;
  logic [PTR_W-1:0]   tail;
  logic [PTR_W:0]     held;
  logic [PTR_W-1:0]   rem_left;
  logic               store_we;
  logic               rm_go;
  logic               fetch_pend;
  logic [PTR_W-1:0]   fetch_addr;
  logic [ENTRY_W-1:0] rd_entry;
  logic               full;
  logic [ALM_W-1:0]   rd_alm;

  rsm_fifo_if #(.W(ENTRY_W)) ob ();

  assign rd_alm   = alm_code(rd_val_i);
  assign full     = (held == (PTR_W+1)'(MEM_DEPTH));
  assign store_we = rd_valid_i && scan_active_i && !rd_direct_i && !mon_meas_o;
  assign rm_go    = (rem_left != '0) && (held != '0) && ob.in_ready && !store_we;
  assign rd_entry = {rd_val_i, rd_ts_i, rd_ch_i, rd_alm};
  assign points_o = held;

  always_ff @(posedge clk_i) begin
    if (store_we) begin
      mem[head] <= rd_entry;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      head           <= '0;
      tail           <= '0;
      held           <= '0;
      rem_left       <= '0;
      mem_overflow_o <= 1'b0;
    end else if (scan_start_i) begin
      head           <= '0;
      tail           <= '0;
      held           <= '0;
      rem_left       <= '0;
      mem_overflow_o <= 1'b0;
    end else begin
      if (remove_i) begin
        rem_left <= remove_n_i;
      end else if (rm_go) begin
        rem_left <= rem_left - 1'b1;
      end
      if (store_we) begin
        head <= wrap({1'b0, head} + 1'b1);
        if (full) begin
          tail           <= wrap({1'b0, tail} + 1'b1);
          mem_overflow_o <= 1'b1;
        end else begin
          held <= held + 1'b1;
        end
      end else if (rm_go) begin
        tail <= wrap({1'b0, tail} + 1'b1);
        held <= held - 1'b1;
      end
    end
  end

  // Fetch reads at tail plus an index and never moves pointers.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fetch_pend <= 1'b0;
      fetch_addr <= '0;
    end else if (fetch_i) begin
      fetch_pend <= 1'b1;
      fetch_addr <= wrap({1'b0, tail} + {1'b0, fetch_idx_i});
    end else if (fetch_pend && ob.in_ready && !rm_go) begin
      fetch_pend <= 1'b0;
    end
  end

  always_comb begin
    ob.in_valid = 1'b0;
    ob.in_data  = '0;
    if (rm_go) begin
      ob.in_valid = 1'b1;
      ob.in_data  = mem[tail];
    end else if (fetch_pend) begin
      ob.in_valid = 1'b1;
      ob.in_data  = mem[fetch_addr];
    end else if (rd_valid_i && rd_direct_i) begin
      ob.in_valid = 1'b1;
      ob.in_data  = rd_entry;
    end
  end

  assign ob.out_ready = out_ready_i;
  assign out_valid_o  = ob.out_valid;
  assign out_data_o   = ob.out_data;

  rsm_fifo #(.W(ENTRY_W), .DEPTH(FIFO_DEPTH), .AW(5)) u_fifo (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .f      (ob)
  );

  // ==========================================================================
  // Per-channel statistics and history
  logic [VAL_W-1:0] s_min  [NUM_CH];
  logic [VAL_W-1:0] s_max  [NUM_CH];
  logic [TS_W-1:0]  s_mint [NUM_CH];
  logic [TS_W-1:0]  s_maxt [NUM_CH];
  logic [SUM_W-1:0] s_sum  [NUM_CH];
  logic [CNT_W-1:0] s_cnt  [NUM_CH];
  logic [VAL_W-1:0] s_last [NUM_CH];
  logic [VAL_W-1:0] hist   [NUM_CH][HIST_DEPTH];
  logic [HIST_W-1:0] h_wp  [NUM_CH];
  logic [3:0] sc;
  logic [3:0] wc;
  logic [HIST_W:0] h_sel;

  assign sc = stat_ch_i[3:0];
  assign wc = rd_ch_i[3:0];

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        s_cnt[i]  <= '0;
        s_sum[i]  <= '0;
        s_min[i]  <= '0;
        s_max[i]  <= '0;
        s_mint[i] <= '0;
        s_maxt[i] <= '0;
        s_last[i] <= '0;
        h_wp[i]   <= '0;
      end
    end else if (scan_start_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        s_cnt[i] <= '0;
        s_sum[i] <= '0;
      end
    end else begin
      if (stat_clr_i) begin
        s_cnt[sc] <= '0;
        s_sum[sc] <= '0;
        s_min[sc] <= '0;
        s_max[sc] <= '0;
      end
      // The history slot is written on every store, so the pointer must move even when a
      // clear of the same channel restarts the statistics.
      if (store_we) begin
        h_wp[wc] <= (h_wp[wc] == HIST_W'(HIST_DEPTH - 1)) ? '0 : h_wp[wc] + 1'b1;
      end
      if (store_we && !(stat_clr_i && sc == wc)) begin
        s_cnt[wc]  <= s_cnt[wc] + 1'b1;
        s_sum[wc]  <= s_sum[wc] + SUM_W'(rd_val_i);
        s_last[wc] <= rd_val_i;
        if (s_cnt[wc] == '0 || rd_val_i < s_min[wc]) begin
          s_min[wc]  <= rd_val_i;
          s_mint[wc] <= rd_ts_i;
        end
        if (s_cnt[wc] == '0 || rd_val_i > s_max[wc]) begin
          s_max[wc]  <= rd_val_i;
          s_maxt[wc] <= rd_ts_i;
        end
      end else if (store_we) begin
        s_cnt[wc]  <= CNT_W'(1);
        s_sum[wc]  <= SUM_W'(rd_val_i);
        s_min[wc]  <= rd_val_i;
        s_max[wc]  <= rd_val_i;
        s_mint[wc] <= rd_ts_i;
        s_maxt[wc] <= rd_ts_i;
        s_last[wc] <= rd_val_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (store_we) begin
      hist[wc][h_wp[wc]] <= rd_val_i;
    end
  end

  // Newest is index 0; the slot just before the write pointer.
  assign h_sel = ({1'b0, h_wp[sc]} >= ((HIST_W+1)'(hist_idx_i) + 1'b1)) ?
                 {1'b0, h_wp[sc]} - (HIST_W+1)'(hist_idx_i) - 1'b1 :
                 {1'b0, h_wp[sc]} + (HIST_W+1)'(HIST_DEPTH) - (HIST_W+1)'(hist_idx_i) - 1'b1;

  // Queries are read only, so local viewing under remote is harmless.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stat_valid_o <= 1'b0;
      stat_min_o   <= '0;
      stat_max_o   <= '0;
      stat_min_t_o <= '0;
      stat_max_t_o <= '0;
      stat_avg_o   <= '0;
      stat_cnt_o   <= '0;
      stat_ptp_o   <= '0;
      stat_last_o  <= '0;
      hist_val_o   <= '0;
    end else begin
      stat_valid_o <= stat_req_i;
      if (stat_req_i) begin
        stat_min_o   <= s_min[sc];
        stat_min_t_o <= s_mint[sc];
        stat_max_o   <= s_max[sc];
        stat_max_t_o <= s_maxt[sc];
        stat_avg_o   <= (s_cnt[sc] == '0) ? '0 : VAL_W'(s_sum[sc] / s_cnt[sc]);
        stat_cnt_o   <= s_cnt[sc];
        stat_ptp_o   <= s_max[sc] - s_min[sc];
        stat_last_o  <= s_last[sc];
        hist_val_o   <= hist[sc][HIST_W'(h_sel)];
      end
    end
  end

  // ==========================================================================
  // Monitor selection, arbitration and alarms
  rsm_mon_type       mstate;
  logic [31:0]       settle;
  logic [CH_W-1:0]   mch;
  logic [1:0]        kind;
  logic              mon_ok;
  logic              owed;
  logic [VAL_W-1:0]  scaled;
  logic              mon_rd;

  assign kind   = ch_kind_i[2*mon_ch_i[3:0] +: 2];
  assign mon_ok = (kind == KIND_MUX) ? (meter_present_i && meter_enable_i &&
                  in_scan_list_i[mon_ch_i[3:0]]) :
                  (kind == KIND_DIG || kind == KIND_TOT);
  assign mon_refused_o     = mon_on_i && !mon_ok;
  assign totalizer_reset_o = 1'b0;
  assign mon_meas_ch_o     = mch;
  assign mon_rd            = rd_valid_i && mon_meas_o;
  assign scaled            = VAL_W'(rd_val_i * scale_m_i + scale_b_i);
  // Scan takes the meter unless a sweep ended without a monitor slot.
  assign mon_meas_o = (mstate == RSM_RUN_TYPE) && meas_ready_i &&
                      (!scan_active_i || owed);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mstate <= RSM_IDLE_TYPE;
      settle <= '0;
      mch    <= '0;
    end else if (!mon_on_i || !mon_ok) begin
      mstate <= RSM_IDLE_TYPE;
    end else if (mon_ch_i != mch || mstate == RSM_IDLE_TYPE) begin
      mch    <= mon_ch_i;
      settle <= '0;
      mstate <= mon_local_i ? RSM_SETTLE_TYPE : RSM_RUN_TYPE;
    end else if (mstate == RSM_SETTLE_TYPE) begin
      settle <= settle + 1'b1;
      if (settle >= 32'(SETTLE_CYCLES - 1)) begin
        mstate <= RSM_RUN_TYPE;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      owed <= 1'b0;
    end else if (sweep_end_i && mstate == RSM_RUN_TYPE) begin
      owed <= 1'b1;
    end else if (mon_meas_o) begin
      owed <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mon_data_o   <= '0;
      alarm_push_o <= 1'b0;
      alarm_data_o <= '0;
      sweep_req_o  <= 1'b0;
    end else begin
      alarm_push_o <= 1'b0;
      sweep_req_o  <= 1'b0;
      if (mon_rd) begin
        mon_data_o <= scaled;
      end
      if (mon_rd && alm_code(scaled) != ALM_NONE) begin
        alarm_push_o <= 1'b1;
        alarm_data_o <= {scaled, rd_ts_i, rd_ch_i, alm_code(scaled)};
      end
      if (alarm_scan_mode_i && rd_valid_i && rd_alm != ALM_NONE) begin
        sweep_req_o <= 1'b1;
      end
    end
  end

  // External instrument handshake is registered for one cycle and passed on as two lines.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ch_closed_o  <= 1'b0;
      ch_advance_o <= 1'b0;
    end else begin
      ch_closed_o  <= ext_closed_i;
      ch_advance_o <= ch_advance_i;
    end
  end

  // ==========================================================================
  // Checks
  no_mon_store_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (mon_meas_o && rd_valid_i && !rm_go && !scan_start_i) |=> $stable(held))
    else $error("Monitor reading stored.");
  no_direct_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rd_valid_i && rd_direct_i && !rm_go && !scan_start_i) |=> $stable(held))
    else $error("Direct reading stored.");
  fetch_keep_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (fetch_i && !remove_i && rem_left == '0 && !store_we && !scan_start_i) |=> $stable(held))
    else $error("Fetch changed count.");
  cnt_drop_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rm_go && !scan_start_i) |=> held == $past(held) - 1'b1) else $error("Remove count wrong.");
  full_keep_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (full && store_we && !scan_start_i) |=> full) else $error("Full store lost entry.");
  cap_max_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    held <= (PTR_W+1)'(MEM_DEPTH)) else $error("Store exceeds capacity.");
  start_clr_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    scan_start_i |=> held == '0) else $error("Scan start left readings.");
  scan_first_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (scan_active_i && !owed) |-> !mon_meas_o) else $error("Monitor beat scan.");
  mon_refuse_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (mon_on_i && !mon_ok) |=> mstate == RSM_IDLE_TYPE) else $error("Refused channel runs.");
  tot_keep_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !totalizer_reset_o) else $error("Monitor reset totalizer.");
  stat_resp_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    stat_req_i |=> stat_valid_o && stat_ptp_o == stat_max_o - stat_min_o)
    else $error("Statistic answer wrong.");
  clr_one_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (stat_clr_i && !scan_start_i && !(store_we && wc == sc)) |=> s_cnt[$past(sc)] == '0)
    else $error("Clear missed channel.");
endmodule // rsm_store

// File: tb/rsm_scan_model.sv
// Scan engine model: emits one reading per cycle while go_i is high.
// Assumes the store samples readings on the rising edge of clk_i.
`timescale 1ns/1ps
module rsm_scan_model
  import rsm_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic             go_i,
  input  wire logic [VAL_W-1:0] val_i,
  output logic                  rd_valid_o,
  output logic [VAL_W-1:0]      rd_val_o,
  output logic [TS_W-1:0]       rd_ts_o
);
  // Idle value lines flip every cycle so stale data never looks valid.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_valid_o <= 1'b0;
      rd_val_o   <= '0;
      rd_ts_o    <= '0;
    end else begin
      rd_valid_o <= go_i;
      rd_val_o   <= go_i ? val_i : ~rd_val_o;
      rd_ts_o    <= rd_ts_o + 32'h0000_0001;
    end
  end
endmodule // rsm_scan_model

// File: tb/testbench.sv
// Self-checking bench for the reading store.
// Assumes the scan model feeds readings and the bench plays the host.
`timescale 1ns/1ps
module testbench;
  import rsm_pkg::*;
  logic clk_i = 0, nrst_i = 0, go = 0;
  logic scan_start_i = 0, scan_active_i = 1, sweep_end_i = 0, alarm_scan_mode_i = 0;
  logic rd_valid_i, rd_direct_i = 0, meas_ready_i = 0, meter_present_i = 1;
  logic meter_enable_i = 1, ext_closed_i = 0, ch_advance_i = 0, fetch_i = 0, remove_i = 0;
  logic stat_req_i = 0, stat_clr_i = 0, out_ready_i = 0, mon_on_i = 0, mon_local_i = 0;
  logic sweep_req_o, mon_meas_o, ch_closed_o, ch_advance_o, stat_valid_o, mem_overflow_o;
  logic out_valid_o, mon_refused_o, alarm_push_o, totalizer_reset_o;
  logic [CH_W-1:0] rd_ch_i = 1, stat_ch_i = 1, mon_ch_i = 0, mon_meas_ch_o;
  logic [VAL_W-1:0] rd_val_i, val = 0, scale_m_i = 0, scale_b_i = 0, lim_lo_i = 0;
  logic [VAL_W-1:0] lim_hi_i = '1, stat_min_o, stat_max_o, stat_avg_o, stat_ptp_o;
  logic [VAL_W-1:0] stat_last_o, hist_val_o, mon_data_o;
  logic [TS_W-1:0] rd_ts_i, stat_min_t_o, stat_max_t_o;
  logic [NUM_CH-1:0] in_scan_list_i = '1;
  logic [2*NUM_CH-1:0] ch_kind_i = '0;
  logic [PTR_W-1:0] fetch_idx_i = 0, remove_n_i = 0;
  logic [HIST_W-1:0] hist_idx_i = 0;
  logic [CNT_W-1:0] stat_cnt_o;
  logic [PTR_W:0] points_o;
  logic [ENTRY_W-1:0] out_data_o, alarm_data_o;
  int fails = 0, checked = 0;
  always #2.5 clk_i = ~clk_i;
  rsm_store #(.SETTLE_CYCLES(20)) rsm_store_inst (.*);
  rsm_scan_model rsm_scan_model_inst (.clk_i(clk_i), .nrst_i(nrst_i), .go_i(go),
    .val_i(val), .rd_valid_o(rd_valid_i), .rd_val_o(rd_val_i), .rd_ts_o(rd_ts_i));
  // ==========================================================
  // Shared tasks.
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic test_done();
    if (fails == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(logic [ENTRY_W-1:0] got, logic [ENTRY_W-1:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Waits for buffered output, checks its value, then accepts it.
  task automatic pop(logic [VAL_W-1:0] exp);
    int i;
    for (i = 0; i < 50 && out_valid_o !== 1'b1; i++) tick();
    if (i == 50) begin
      fails++;
      test_done();
    end
    chk(out_data_o[ENTRY_W-1 -: VAL_W], exp);
    out_ready_i = 1;
    tick();
    out_ready_i = 0;
  endtask
  task automatic feed(logic [VAL_W-1:0] v);
    go = 1;
    val = v;
    tick();
    go = 0;
    tick();
  endtask
  // ==========================================================
  // Scenarios.
  task automatic t_store();
    scan_start_i = 1;
    tick();
    scan_start_i = 0;
    feed(5);
    feed(9);
    feed(2);
    chk(points_o, 3);
    rd_direct_i = 1;
    feed(7);
    rd_direct_i = 0;
    chk(points_o, 3);
    pop(7);
  endtask
  task automatic t_remove();
    remove_n_i = 2;
    remove_i = 1;
    tick();
    remove_i = 0;
    pop(5);
    pop(9);
    tick(2);
    chk(points_o, 1);
    fetch_i = 1;
    tick();
    fetch_i = 0;
    pop(2);
    chk(points_o, 1);
  endtask
  task automatic t_stats();
    stat_req_i = 1;
    tick();
    stat_req_i = 0;
    chk(stat_valid_o, 1);
    chk(stat_cnt_o, 3);
    chk(stat_min_o, 2);
    chk(stat_max_o, 9);
    chk(stat_ptp_o, 7);
    chk(stat_avg_o, 5);
    chk(stat_min_t_o - stat_max_t_o, 2);
    chk(hist_val_o, 2);
    chk(stat_last_o, 2);
    stat_clr_i = 1;
    tick();
    stat_clr_i = 0;
    hist_idx_i = 2;
    stat_req_i = 1;
    tick();
    stat_req_i = 0;
    chk(stat_cnt_o, 0);
    chk(stat_max_o, 0);
    chk(stat_avg_o, 0);
    chk(hist_val_o, 5);
    chk(points_o, 1);
  endtask
  task automatic t_monitor();
    scan_active_i = 0;
    meas_ready_i = 1;
    scale_m_i = 2;
    scale_b_i = 3;
    lim_hi_i = 10;
    mon_on_i = 1;
    feed(5);
    chk(mon_data_o, 13);
    chk(alarm_push_o, 1);
    chk(alarm_data_o[1:0], ALM_HI);
    scan_active_i = 1;
    sweep_end_i = 1;
    go = 1;
    val = 4;
    tick();
    sweep_end_i = 0;
    go = 0;
    chk(mon_meas_o, 1);
    tick();
    chk(mon_data_o, 11);
    chk(points_o, 1);
    feed(6);
    chk(points_o, 2);
    chk(mon_meas_o, 0);
    scan_active_i = 0;
    ch_kind_i = 32'h0000_0030;
    mon_ch_i = 2;
    tick();
    chk(mon_refused_o, 1);
    chk(mon_meas_o, 0);
    mon_ch_i = 3;
    meter_enable_i = 0;
    tick();
    chk(mon_refused_o, 1);
    ch_kind_i = 32'h0000_0020;
    mon_ch_i = 2;
    in_scan_list_i = '0;
    tick();
    chk(mon_refused_o, 0);
    chk(mon_meas_o, 1);
    chk(totalizer_reset_o, 0);
    meter_enable_i = 1;
    in_scan_list_i = '1;
    mon_ch_i = 3;
    mon_local_i = 1;
    tick();
    chk(mon_meas_ch_o, 3);
    chk(mon_meas_o, 0);
    tick(19);
    chk(mon_meas_o, 0);
    tick();
    chk(mon_meas_o, 1);
    mon_on_i = 0;
    mon_local_i = 0;
    meas_ready_i = 0;
    scan_active_i = 1;
    alarm_scan_mode_i = 1;
    feed(20);
    chk(sweep_req_o, 1);
    alarm_scan_mode_i = 0;
    ext_closed_i = 1;
    ch_advance_i = 1;
    tick();
    chk(ch_closed_o, 1);
    chk(ch_advance_o, 1);
  endtask
  task automatic t_newscan();
    scan_start_i = 1;
    tick();
    scan_start_i = 0;
    feed(7);
    go = 1;
    val = 1;
    tick(MEM_DEPTH);
    go = 0;
    tick();
    chk(points_o, MEM_DEPTH);
    chk(mem_overflow_o, 1);
    fetch_i = 1;
    tick();
    fetch_i = 0;
    pop(1);
    scan_start_i = 1;
    tick();
    scan_start_i = 0;
    tick();
    chk(points_o, 0);
    chk(mem_overflow_o, 0);
  endtask
  initial begin
    tick(6);
    nrst_i = 1;
    tick();
    t_store();
    t_remove();
    t_stats();
    t_monitor();
    t_newscan();
    test_done();
  end
endmodule // testbench
